// ### pmc_consts.svh
// constants for the cpu power mode controller
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_ADDR_POWER_CONTROL 8'h87
`define PMC_RESET_POWER_CONTROL 8'h00
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_BIT_FLAGS_LO 2
`define PMC_BIT_FLAGS_HI 6
`define PMC_BIT_BAUD_DOUBLER 7
`define PMC_RESET_VECTOR 16'h0000
`define PMC_CLK_PERIOD_NS 100
`define PMC_LCD_TIMEOUT_US 100
`define PMC_LCD_TIMEOUT_CYC ((`PMC_LCD_TIMEOUT_US * 1000) / `PMC_CLK_PERIOD_NS)
`define PMC_RESET_HOLD_CYC 4

`endif

// ### pmc_pkg.sv
// types for the cpu power mode controller
`default_nettype none

package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_STOP,
        PMC_RESET
    } pmc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmc_bus_t;

    typedef struct packed {
        logic insn_done;
        logic irq_pending;
        logic wdt_expire;
        logic ext_reset;
    } pmc_event_t;
endpackage

`default_nettype wire

// ### pmc_power_mode.sv
// power control register with idle and stop mode sequencing
// ----------------------------------------------------------------
// How it works
// - idle starts only after the instruction that set the idle bit completes
// - idle gates only the cpu clock; peripherals, timers, interrupts keep running
// - enabled interrupt in idle clears idle bit and resumes the cpu
// - reset ending idle runs reset sequence, fetch restarts at address zero
// - enabled watchdog keeps counting in idle; its expiry resets the core
// - stop starts after the setting instruction; cpu and oscillators halt
// - only a reset ends stop; interrupts are ignored there
// - lost clock detector stays armed in stop and resets when enabled
// - idle and stop bits always read back as zero
// - top bit doubles the serial baud rate when one
// - bits six to two are plain storage flags
// ----------------------------------------------------------------
//
// Decided for this implementation: the strobed register port.
`default_nettype none
`include "pmc_consts.svh"

module pmc_power_mode (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pmc_pkg::pmc_bus_t i_bus,
    input wire logic i_insn_done,
    input wire logic i_irq_pending,
    input wire logic i_wdt_enable,
    input wire logic i_wdt_expire,
    input wire logic i_lcd_enable,
    input wire logic i_ext_reset_n,
    output logic [7:0] o_rdata,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_osc_en,
    output logic o_core_reset,
    output logic [15:0] o_fetch_addr,
    output logic o_baud_doubler,
    output logic [4:0] o_general_flags,
    output pmc_pkg::pmc_mode_t o_mode
);
    import pmc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pmc_mode_t mode;
        logic baud_doubler;
        logic [4:0] general_flags;
        logic idle_req;
        logic stop_req;
        logic [7:0] rdata;
        logic [1:0] ext_sync;
        logic [10:0] lcd_cnt;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic core_reset;
        logic [15:0] fetch_addr;
    } pmc_state_t;

    pmc_state_t state;
    pmc_state_t next_state;
    logic rs_active;
    logic rs_done;
    logic reset_req;
    logic lcd_fire;

    function automatic logic hit(input pmc_bus_t b, input logic strobe);
        hit = strobe && (b.addr == `PMC_ADDR_POWER_CONTROL);
    endfunction

    // ------------------------------------------------------------
    // reset request and stretcher
    // ------------------------------------------------------------
    // watchdog expiry, lost clock and external pin all restart the core
    assign lcd_fire = i_lcd_enable && (state.mode == PMC_STOP)
                      && (state.lcd_cnt == 11'(`PMC_LCD_TIMEOUT_CYC - 1));
    assign reset_req = (i_wdt_enable && i_wdt_expire)
                       || lcd_fire
                       || !state.ext_sync[1];

    pmc_reset_stretch u_stretch (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_req(reset_req),
        .o_active(rs_active),
        .o_done(rs_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.ext_sync = {state.ext_sync[0], i_ext_reset_n};
        next_state.rdata = 8'h00;

        // register write; mode bits only request, they are never stored
        if (hit(i_bus, i_bus.wr) && (state.mode == PMC_RUN)) begin
            next_state.baud_doubler = i_bus.wdata[`PMC_BIT_BAUD_DOUBLER];
            next_state.general_flags =
                i_bus.wdata[`PMC_BIT_FLAGS_HI:`PMC_BIT_FLAGS_LO];
            if (i_bus.wdata[`PMC_BIT_STOP]) begin
                next_state.stop_req = 1'b1;
            end else if (i_bus.wdata[`PMC_BIT_IDLE]) begin
                next_state.idle_req = 1'b1;
            end
        end
        if (hit(i_bus, i_bus.rd)) begin
            next_state.rdata = {state.baud_doubler, state.general_flags, 2'b00};
        end

        // lost clock detector counts only while stopped
        if (state.mode == PMC_STOP) begin
            next_state.lcd_cnt = state.lcd_cnt + 11'h001;
        end else begin
            next_state.lcd_cnt = 11'h000;
        end

        case (state.mode)
            PMC_RUN: begin
                // wait for the setting instruction to finish
                if (i_insn_done && (state.stop_req || next_state.stop_req)) begin
                    next_state.mode = PMC_STOP;
                    next_state.stop_req = 1'b0;
                    next_state.idle_req = 1'b0;
                    next_state.cpu_clk_en = 1'b0;
                    next_state.periph_clk_en = 1'b0;
                    next_state.osc_en = 1'b0;
                end else if (i_insn_done && (state.idle_req || next_state.idle_req)) begin
                    next_state.mode = PMC_IDLE;
                    next_state.idle_req = 1'b0;
                    next_state.cpu_clk_en = 1'b0;
                end
            end
            PMC_IDLE: begin
                if (i_irq_pending) begin
                    next_state.mode = PMC_RUN;
                    next_state.cpu_clk_en = 1'b1;
                end
            end
            PMC_STOP: begin
                // interrupts are not looked at here
                next_state.cpu_clk_en = 1'b0;
            end
            PMC_RESET: begin
                next_state.cpu_clk_en = 1'b0;
                if (rs_done) begin
                    next_state.mode = PMC_RUN;
                    next_state.cpu_clk_en = 1'b1;
                    next_state.core_reset = 1'b0;
                end
            end
            default: begin
                next_state.mode = PMC_RUN;
            end
        endcase

        // any reset wins over every mode
        if (reset_req || rs_active) begin
            next_state.mode = PMC_RESET;
            next_state.core_reset = 1'b1;
            next_state.cpu_clk_en = 1'b0;
            next_state.periph_clk_en = 1'b1;
            next_state.osc_en = 1'b1;
            next_state.idle_req = 1'b0;
            next_state.stop_req = 1'b0;
            next_state.baud_doubler = 1'b0;
            next_state.general_flags = 5'h00;
            next_state.fetch_addr = `PMC_RESET_VECTOR;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state.mode <= PMC_RUN;
            state.baud_doubler <= 1'b0;
            state.general_flags <= 5'h00;
            state.idle_req <= 1'b0;
            state.stop_req <= 1'b0;
            state.rdata <= 8'h00;
            state.ext_sync <= 2'b11;
            state.lcd_cnt <= 11'h000;
            state.cpu_clk_en <= 1'b1;
            state.periph_clk_en <= 1'b1;
            state.osc_en <= 1'b1;
            state.core_reset <= 1'b0;
            state.fetch_addr <= `PMC_RESET_VECTOR;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_cpu_clk_en = state.cpu_clk_en;
    assign o_periph_clk_en = state.periph_clk_en;
    assign o_osc_en = state.osc_en;
    assign o_core_reset = state.core_reset;
    assign o_fetch_addr = state.fetch_addr;
    assign o_baud_doubler = state.baud_doubler;
    assign o_general_flags = state.general_flags;
    assign o_mode = state.mode;
endmodule // pmc_power_mode

`default_nettype wire

// ### pmc_power_mode_sva.sv
// assertions for the power mode controller
`default_nettype none

module pmc_power_mode_sva (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pmc_pkg::pmc_bus_t i_bus,
    input wire logic i_insn_done,
    input wire logic i_irq_pending,
    input wire logic i_wdt_enable,
    input wire logic i_wdt_expire,
    input wire logic i_lcd_enable,
    input wire logic i_ext_reset_n,
    input wire logic [7:0] o_rdata,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_osc_en,
    input wire logic o_core_reset,
    input wire logic [15:0] o_fetch_addr,
    input wire logic o_baud_doubler,
    input wire logic [4:0] o_general_flags,
    input wire pmc_pkg::pmc_mode_t o_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------
    // pin history covers the reset synchroniser delay
    // ------------------------------------------------
    logic [2:0] pin_hist;
    logic calm;
    logic wr_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_hist <= 3'h7;
        end else begin
            pin_hist <= {pin_hist[1:0], i_ext_reset_n};
        end
    end
    assign calm = (&pin_hist) && i_ext_reset_n && !(i_wdt_enable && i_wdt_expire);
    assign wr_reg = i_bus.wr && i_bus.addr == 8'h87 && o_mode == PMC_RUN && calm;
    idle_entry_a: assert property (wr_reg && i_insn_done &&
        i_bus.wdata[1:0] == 2'h1 |=>
        o_mode == PMC_IDLE && !o_cpu_clk_en && o_periph_clk_en && o_osc_en)
        else $error("idle not entered after completed write");
    idle_wait_a: assert property (wr_reg && !i_insn_done |=>
        o_mode == PMC_RUN && o_cpu_clk_en)
        else $error("mode changed before instruction completed");
    idle_wake_a: assert property (o_mode == PMC_IDLE && i_irq_pending && calm |=>
        o_mode == PMC_RUN && o_cpu_clk_en)
        else $error("interrupt did not end idle");
    stop_entry_a: assert property (wr_reg && i_insn_done && i_bus.wdata[1] |=>
        o_mode == PMC_STOP && !o_osc_en && !o_periph_clk_en && !o_cpu_clk_en)
        else $error("stop not entered after completed write");
    stop_hold_a: assert property (o_mode == PMC_STOP && calm && !i_lcd_enable |=>
        o_mode == PMC_STOP)
        else $error("stop left without reset");
    wdt_reset_a: assert property (i_wdt_enable && i_wdt_expire && o_mode == PMC_IDLE |=>
        o_core_reset && o_mode == PMC_RESET)
        else $error("watchdog expiry did not reset idle core");
    read_back_a: assert property (i_bus.rd && i_bus.addr == 8'h87 && calm &&
        o_mode != PMC_STOP |=>
        o_rdata == {o_baud_doubler, o_general_flags, 2'h0})
        else $error("read data differs from stored bits");
    flag_write_a: assert property (wr_reg |=>
        {o_baud_doubler, o_general_flags} == $past(i_bus.wdata[7:2]))
        else $error("flags not updated by write");
    restart_vec_a: assert property ($fell(o_core_reset) |->
        o_fetch_addr == 16'h0000 && o_mode == PMC_RUN && o_cpu_clk_en)
        else $error("bad state on reset release");
endmodule // pmc_power_mode_sva

bind pmc_power_mode pmc_power_mode_sva pmc_power_mode_sva_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_bus(i_bus), .i_insn_done(i_insn_done), .i_irq_pending(i_irq_pending),
    .i_wdt_enable(i_wdt_enable), .i_wdt_expire(i_wdt_expire), .i_lcd_enable(i_lcd_enable),
    .i_ext_reset_n(i_ext_reset_n), .o_rdata(o_rdata), .o_cpu_clk_en(o_cpu_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en), .o_core_reset(o_core_reset),
    .o_fetch_addr(o_fetch_addr), .o_baud_doubler(o_baud_doubler),
    .o_general_flags(o_general_flags), .o_mode(o_mode));

`default_nettype wire

// ### pmc_power_mode_tb_top.sv
// self-checking bench for the power mode controller
`default_nettype none

module pmc_power_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    logic i_clk, i_rst_n, insn, irq, wdt_en, wdt_exp, lcd_en, pin_n;
    pmc_bus_t bus;
    logic [7:0] rdata;
    logic cpu_en, per_en, osc_en, core_rst, baud;
    logic [15:0] fetch;
    logic [4:0] flags;
    pmc_mode_t mode;
    int mismatches, samples_checked;

    pmc_power_mode pmc_power_mode_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
        .i_insn_done(insn), .i_irq_pending(irq), .i_wdt_enable(wdt_en), .i_wdt_expire(wdt_exp),
        .i_lcd_enable(lcd_en), .i_ext_reset_n(pin_n), .o_rdata(rdata), .o_cpu_clk_en(cpu_en),
        .o_periph_clk_en(per_en), .o_osc_en(osc_en), .o_core_reset(core_rst),
        .o_fetch_addr(fetch), .o_baud_doubler(baud), .o_general_flags(flags), .o_mode(mode));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // ------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
        @(posedge i_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        insn <= done;
        @(posedge i_clk);
        bus <= '0;
        insn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk);
        bus <= '0;
        #1;
        check("rdata", rdata, exp);
    endtask
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (core_rst !== lvl) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > 1500) begin
                mismatches++;
                end_of_test();
            end
        end
    endtask
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        i_rst_n = 1'b0;
        bus = '0;
        insn = 1'b0;
        irq = 1'b0;
        wdt_en = 1'b0;
        wdt_exp = 1'b0;
        lcd_en = 1'b0;
        pin_n = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        check("mode", mode, PMC_RUN);
        check("enables", {cpu_en, per_en, osc_en, core_rst}, 4'he);
        rd(8'h87, 8'h00);
        wr(8'h87, 8'hfc, 1'b1);
        rd(8'h87, 8'hfc);
        check("outs", {baud, flags}, 6'h3f);
        wr(8'h86, 8'h00, 1'b1);
        rd(8'h86, 8'h00);
        wr(8'h87, 8'h7d, 1'b0);
        check("mode", mode, PMC_RUN);
        @(posedge i_clk);
        insn <= 1'b1;
        @(posedge i_clk);
        insn <= 1'b0;
        #1;
        check("mode", mode, PMC_IDLE);
        check("enables", {cpu_en, per_en, osc_en}, 3'h3);
        rd(8'h87, 8'h7c);
        wr(8'h87, 8'h00, 1'b1);
        check("outs", {baud, flags}, 6'h1f);
        @(posedge i_clk);
        irq <= 1'b1;
        @(posedge i_clk);
        irq <= 1'b0;
        #1;
        check("mode", mode, PMC_RUN);
        check("cpu", cpu_en, 1'b1);
        wr(8'h87, 8'h01, 1'b1);
        @(posedge i_clk);
        wdt_en <= 1'b1;
        wdt_exp <= 1'b1;
        @(posedge i_clk);
        wdt_exp <= 1'b0;
        #1;
        check("mode", mode, PMC_RESET);
        wait_rst(1'b0);
        check("fetch", fetch, 16'h0000);
        rd(8'h87, 8'h00);
        wr(8'h87, 8'h02, 1'b1);
        check("enables", {mode, cpu_en, per_en, osc_en}, {PMC_STOP, 3'h0});
        @(posedge i_clk);
        irq <= 1'b1;
        repeat (5) @(posedge i_clk);
        irq <= 1'b0;
        pin_n <= 1'b0;
        #1;
        check("mode", mode, PMC_STOP);
        wait_rst(1'b1);
        @(posedge i_clk);
        pin_n <= 1'b1;
        wait_rst(1'b0);
        check("mode", mode, PMC_RUN);
        @(posedge i_clk);
        lcd_en <= 1'b1;
        wr(8'h87, 8'h02, 1'b1);
        check("mode", mode, PMC_STOP);
        wait_rst(1'b1);
        check("mode", mode, PMC_RESET);
        wait_rst(1'b0);
        check("fetch", fetch, 16'h0000);
        end_of_test();
    end
endmodule // pmc_power_mode_tb_top

`default_nettype wire

// ### pmc_reset_stretch.sv
// stretches watchdog, lost clock and external pin reset requests; o_active stays high four cycles past the last request
`default_nettype none
`include "pmc_consts.svh"

module pmc_reset_stretch (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    output logic o_active,
    output logic o_done
);
    typedef struct packed {
        logic [3:0] cnt;
        logic active;
        logic done;
    } pmc_rs_state_t;

    pmc_rs_state_t state;
    pmc_rs_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (i_req) begin
            next_state.active = 1'b1;
            next_state.cnt = 4'(`PMC_RESET_HOLD_CYC - 1);
        end else if (state.active) begin
            if (state.cnt == 4'h0) begin
                next_state.active = 1'b0;
                next_state.done = 1'b1;
            end else begin
                next_state.cnt = state.cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_active = state.active;
    assign o_done = state.done;
endmodule // pmc_reset_stretch

`default_nettype wire
